// ### common/jrc_pkg.sv
package jrc_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [11:0] JRC_IDX_CTRL0 = 12'h300;
  localparam logic [11:0] JRC_IDX_SUBCLASS = 12'h301;
  localparam logic [11:0] JRC_IDX_LAT0 = 12'h302;
  localparam logic [11:0] JRC_IDX_LAT1 = 12'h303;
  localparam logic [11:0] JRC_IDX_PAGED_LO = 12'h401;
  localparam logic [11:0] JRC_IDX_PAGED_HI = 12'h47E;
  // field positions
  localparam int JRC_LINK_MODE_BIT = 3;
  localparam int JRC_LINK_PAGE_BIT = 2;
  localparam int JRC_LINK_EN_LSB = 0;
  localparam int JRC_LAT_W = 5;
  localparam int JRC_SUB_W = 3;
  // reset values
  localparam logic [1:0] JRC_LINK_EN_RST = 2'h0;
  localparam logic JRC_LINK_MODE_RST = 1'b0;
  localparam logic JRC_LINK_PAGE_RST = 1'b0;
  localparam logic [2:0] JRC_SUB_RST = 3'h1;
  localparam logic [4:0] JRC_LAT_RST = 5'h00;
  // paged bank: 128 words per link, of which offsets 0x01 to 0x7E (126) are reachable through the window
  localparam int JRC_BANK_DEPTH = 128;
  localparam int JRC_BANK_AW = 8;
endpackage

// ### hw/jrc_bank_mem.sv
`timescale 1ns/1ps
// two link parameter banks, word selected by {page, offset}; registered read data
module jrc_bank_mem (
  input wire logic mclk,
  input wire logic we,
  input wire logic [jrc_pkg::JRC_BANK_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:2*jrc_pkg::JRC_BANK_DEPTH-1];
  // write then registered read
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // jrc_bank_mem

// ### hw/jrc_regs.sv
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module jrc_regs (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [4:0] latency0_in,
  input wire logic [4:0] latency1_in,
  output logic [1:0] link_enable,
  output logic link_mode,
  output logic link_page,
  output logic [2:0] subclass_select
);
  // bus decode
  logic [11:0] idx;
  logic wr_acc, bank_hit, lane0;
  // control fields
  logic [1:0] en_q, en_d;
  logic mode_q, mode_d, page_q, page_d;
  logic [2:0] sub_q, sub_d;
  logic [1:0] link_en_q, link_en_d;
  // latency synchronisers and held values
  logic [4:0] s0a_q, s0b_q, s1a_q, s1b_q;
  logic [4:0] s0c_q, s1c_q, lat0_d, lat1_d;
  logic [4:0] lat0_q, lat1_q;
  // bus answer state
  logic wait_q, wait_d;
  logic [31:0] rd_q, rd_d;
  logic ready_q, ready_d, err_q, err_d;
  logic [7:0] bank_rd;
  logic [jrc_pkg::JRC_BANK_AW-1:0] bank_addr;
  logic [6:0] bank_off;

  assign idx = paddr[13:2];
  assign lane0 = pstrb[0];
  // a write lands only at the edge where the master sees pready high
  assign wr_acc = psel && penable && pwrite && ready_q && !bank_hit;
  assign bank_hit = (idx >= jrc_pkg::JRC_IDX_PAGED_LO) && (idx <= jrc_pkg::JRC_IDX_PAGED_HI);
  assign bank_off = idx[6:0];
  // page bit picks which link bank the window reaches
  assign bank_addr = {page_q, bank_off};

  jrc_bank_mem u_bank (
    .mclk(mclk),
    .we(psel && penable && pwrite && bank_hit && lane0 && ready_q),
    .addr(bank_addr),
    .wdata(pwdata[7:0]),
    .rdata(bank_rd)
  );

  // control register next values
  always_comb begin
    en_d = en_q;
    mode_d = mode_q;
    page_d = page_q;
    sub_d = sub_q;
    if (wr_acc && lane0 && idx == jrc_pkg::JRC_IDX_CTRL0) begin
      en_d = pwdata[jrc_pkg::JRC_LINK_EN_LSB +: 2];
      mode_d = pwdata[jrc_pkg::JRC_LINK_MODE_BIT];
      page_d = pwdata[jrc_pkg::JRC_LINK_PAGE_BIT];
    end
    if (wr_acc && lane0 && idx == jrc_pkg::JRC_IDX_SUBCLASS) begin
      sub_d = pwdata[jrc_pkg::JRC_SUB_W-1:0];
    end
    link_en_d = {en_d[1] && mode_d, en_d[0]};
  end

  // a synchronised latency word is taken only once two samples agree,
  // so a word caught mid-change never reaches software
  always_comb begin
    lat0_d = lat0_q;
    lat1_d = lat1_q;
    if (s0b_q == s0c_q) begin
      lat0_d = s0b_q;
    end
    if (s1b_q == s1c_q) begin
      lat1_d = s1b_q;
    end
  end

  // bus answer: one wait cycle so the bank's registered read data is ready
  always_comb begin
    wait_d = 1'b0;
    ready_d = 1'b0;
    err_d = 1'b0;
    rd_d = rd_q;
    if (psel && penable && !ready_q) begin
      if (!wait_q) begin
        wait_d = 1'b1;
      end else begin
        ready_d = 1'b1;
        rd_d = 32'h0000_0000;
        case (1'b1)
          (idx == jrc_pkg::JRC_IDX_CTRL0): rd_d[3:0] = {mode_q, page_q, en_q};
          (idx == jrc_pkg::JRC_IDX_SUBCLASS): rd_d[2:0] = sub_q;
          (idx == jrc_pkg::JRC_IDX_LAT0): rd_d[4:0] = lat0_q;
          (idx == jrc_pkg::JRC_IDX_LAT1): rd_d[4:0] = lat1_q;
          bank_hit: rd_d[7:0] = bank_rd;
          default: err_d = 1'b1;
        endcase
        if (pwrite) begin
          rd_d = 32'h0000_0000;
        end
      end
    end
  end

  // register stage; latency inputs come from another domain, two flops first
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      en_q <= jrc_pkg::JRC_LINK_EN_RST;
      mode_q <= jrc_pkg::JRC_LINK_MODE_RST;
      page_q <= jrc_pkg::JRC_LINK_PAGE_RST;
      sub_q <= jrc_pkg::JRC_SUB_RST;
      s0a_q <= jrc_pkg::JRC_LAT_RST;
      s0b_q <= jrc_pkg::JRC_LAT_RST;
      s1a_q <= jrc_pkg::JRC_LAT_RST;
      s1b_q <= jrc_pkg::JRC_LAT_RST;
      lat0_q <= jrc_pkg::JRC_LAT_RST;
      lat1_q <= jrc_pkg::JRC_LAT_RST;
      s0c_q <= jrc_pkg::JRC_LAT_RST;
      s1c_q <= jrc_pkg::JRC_LAT_RST;
      link_en_q <= jrc_pkg::JRC_LINK_EN_RST;
      wait_q <= 1'b0;
      ready_q <= 1'b0;
      err_q <= 1'b0;
      rd_q <= 32'h0000_0000;
    end else begin
      en_q <= en_d;
      mode_q <= mode_d;
      page_q <= page_d;
      sub_q <= sub_d;
      s0a_q <= latency0_in;
      s0b_q <= s0a_q;
      s1a_q <= latency1_in;
      s1b_q <= s1a_q;
      s0c_q <= s0b_q;
      s1c_q <= s1b_q;
      lat0_q <= lat0_d;
      lat1_q <= lat1_d;
      link_en_q <= link_en_d;
      wait_q <= wait_d;
      ready_q <= ready_d;
      err_q <= err_d;
      rd_q <= rd_d;
    end
  end

  assign prdata = rd_q;
  assign pready = ready_q;
  assign pslverr = err_q;
  // link 1 runs only in dual-link mode; the gated copy has its own flop
  assign link_enable = link_en_q;
  assign link_mode = mode_q;
  assign link_page = page_q;
  assign subclass_select = sub_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // control writes take effect at the completing edge
  en_write_a: assert property (wr_acc && lane0 && idx == jrc_pkg::JRC_IDX_CTRL0
    |=> en_q == $past(pwdata[1:0])) else $error("link enable not stored");
  dis_both_a: assert property (wr_acc && lane0 && idx == jrc_pkg::JRC_IDX_CTRL0
    && pwdata[1:0] == 2'h0 |=> link_enable == 2'h0) else $error("links not disabled");
  only_zero_a: assert property (wr_acc && lane0 && idx == jrc_pkg::JRC_IDX_CTRL0
    && pwdata[1:0] == 2'h1 |=> link_enable == 2'h1) else $error("link 0 only failed");
  strb_hold_a: assert property (psel && penable && pwrite && ready_q && !lane0
    |=> $stable(en_q)) else $error("link enable changed without strobe");
  mode_gate_a: assert property (!mode_q |-> !link_enable[1])
    else $error("link 1 on in single mode");
  dual_pass_a: assert property (mode_q |-> link_enable == en_q)
    else $error("link enable not passed in dual mode");
  // page bit steers the bank window
  page_write_a: assert property (wr_acc && lane0 && idx == jrc_pkg::JRC_IDX_CTRL0
    |=> bank_addr[7] == $past(pwdata[jrc_pkg::JRC_LINK_PAGE_BIT]))
    else $error("bank page wrong");
  // latency words: first flop feeds only the second, values taken when steady
  sync0_in_a: assert property (1'b1 |=> s0a_q == $past(latency0_in))
    else $error("latency 0 not captured");
  sync1_in_a: assert property (1'b1 |=> s1a_q == $past(latency1_in))
    else $error("latency 1 not captured");
  lat_sync_a: assert property (s0b_q == s0c_q |=> lat0_q == $past(s0b_q))
    else $error("latency 0 path wrong");
  lat1_sync_a: assert property (s1b_q == s1c_q |=> lat1_q == $past(s1b_q))
    else $error("latency 1 path wrong");
  lat_hold_a: assert property (s0b_q != s0c_q |=> $stable(lat0_q))
    else $error("latency 0 taken while moving");
  lat1_hold_a: assert property (s1b_q != s1c_q |=> $stable(lat1_q))
    else $error("latency 1 taken while moving");
  lat0_read_a: assert property (psel && penable && wait_q && !ready_q && !pwrite
    && idx == jrc_pkg::JRC_IDX_LAT0 |=> prdata == {27'h0, $past(lat0_q)})
    else $error("latency 0 read wrong");
  lat_read_a: assert property (psel && penable && wait_q && !ready_q && !pwrite
    && idx == jrc_pkg::JRC_IDX_LAT1 |=> prdata == {27'h0, $past(lat1_q)})
    else $error("latency 1 read wrong");
  // answer timing: two access edges, then pready for one cycle
  ready_two_a: assert property (psel && !penable ##1 psel && penable
    |-> ##1 !pready ##1 pready) else $error("answer timing wrong");
  ready_one_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_with_a: assert property (pslverr |-> pready)
    else $error("error without answer");

  // main scenarios
  wr_ctrl_c: cover property (wr_acc && idx == jrc_pkg::JRC_IDX_CTRL0);
  rd_bank_c: cover property (pready && bank_hit && page_q);
  err_c: cover property (pslverr);
  lat_upd_c: cover property ($changed(lat0_q));
  dual_on_c: cover property (link_enable == 2'h3);
endmodule // jrc_regs

// ### bench/jrc_link_model.sv
`timescale 1ns/1ps
module jrc_link_model (
  input wire logic mclk,
  input wire logic [4:0] set0,
  input wire logic [4:0] set1,
  output logic [4:0] lat0,
  output logic [4:0] lat1
);
  // link logic reports measured latency, held until remeasured
  always_ff @(posedge mclk) begin
    lat0 <= set0;
    lat1 <= set1;
  end
endmodule // jrc_link_model

// ### bench/jesd_rx_link_control_regs_tb.sv
`timescale 1ns/1ps
module jesd_rx_link_control_regs_tb;
  typedef struct packed {
    logic [3:0] w; logic [11:0] a; logic [7:0] d; logic [7:0] e; logic [3:0] r;
  } jrc_row_t;
  logic mclk = 1'h0;
  logic sys_rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, link_mode, link_page;
  logic [4:0] lat0, lat1;
  logic [4:0] set0 = 5'h13;
  logic [1:0] link_enable;
  logic [2:0] subclass_select;
  int err_total = 0;
  int cmp_count = 0;
  // write, index, data, expected read, expected error
  jrc_row_t rows[] = '{
    36'h1_300_0C_00_0, 36'h1_401_A5_00_0, 36'h1_47E_3C_00_0, // bank first
    36'h1_300_08_00_0, 36'h1_401_5A_00_0, 36'h0_401_00_5A_0,
    36'h1_300_0C_00_0, 36'h0_401_00_A5_0, 36'h0_47E_00_3C_0,
    36'h1_300_0B_00_0, 36'h0_300_00_0B_0,
    36'h1_300_09_00_0, 36'h0_300_00_09_0,
    36'h1_300_08_00_0, 36'h0_300_00_08_0,
    36'h1_300_02_00_0, 36'h0_300_00_02_0,
    36'h1_301_00_00_0, 36'h0_301_00_00_0,
    36'h1_302_1F_00_0, 36'h0_302_00_13_0, 36'h0_303_00_0C_0,
    36'h0_3FF_00_00_1};
  jrc_link_model u_far (.mclk(mclk), .set0(set0), .set1(5'h0C), .lat0(lat0), .lat1(lat1));
  jrc_regs u_dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .latency0_in(lat0), .latency1_in(lat1),
    .link_enable(link_enable), .link_mode(link_mode), .link_page(link_page),
    .subclass_select(subclass_select));
  // free-running clock
  always #10 mclk = ~mclk;
  task automatic results;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // one transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {a, 2'h0};
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      err_total++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge mclk);
  endtask
  // table pass, then reset and strobe cases
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'h0;
    foreach (rows[i]) begin
      apb(rows[i].w[0], rows[i].a, rows[i].d, 4'hF);
      if (!rows[i].w[0]) chk(rd, {24'h0, rows[i].e});
      chk({31'h0, er}, {31'h0, rows[i].r[0]});
    end
    apb(1'h1, 12'h300, 8'h0B, 4'hF);
    chk({link_mode, link_page, link_enable, subclass_select}, 32'h58);
    sys_rst <= 1'h1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'h0;
    apb(1'h0, 12'h300, 8'h00, 4'hF);
    chk(rd, 32'h0);
    apb(1'h0, 12'h301, 8'h00, 4'hF);
    chk(rd, 32'h1);
    apb(1'h1, 12'h300, 8'h01, 4'h0);
    apb(1'h0, 12'h300, 8'h00, 4'hF);
    chk(rd, 32'h0);
    apb(1'h1, 12'h300, 8'h02, 4'hF);
    chk({30'h0, link_enable}, 32'h0);
    apb(1'h1, 12'h300, 8'h09, 4'hF);
    chk({30'h0, link_enable}, 32'h1);
    set0 <= 5'h07;
    repeat (8) @(posedge mclk);
    apb(1'h0, 12'h302, 8'h00, 4'hF);
    chk(rd, 32'h7);
    results();
  end
endmodule // jesd_rx_link_control_regs_tb
